// *** glue_pkg.sv ***
// Package of constants and carrier types for the CPU-to-peripheral glue logic
package glue_pkg;

    // Default wait-state counts for the faster peripheral grade
    localparam int RD_WAITS_DEF      = 1;
    localparam int WR_WAITS_DEF      = 1;
    // Acknowledge shift register length and default tap for read/wait release
    localparam int ACK_SR_LEN_DEF    = 8;
    localparam int ACK_RD_TAP_DEF    = 3;
    localparam int WAIT_CNT_W        = 4;
    localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_ZERO = 4'h0;

    // CPU bus strobes, all active low, as seen after synchronisation
    typedef struct packed {
        logic opcode_fetch_n;
        logic memory_request_n;
        logic io_request_n;
        logic rd_n;
        logic wr_n;
    } cpu_strobes_t;

    // Strobes to the peripheral family, active low
    typedef struct packed {
        logic irq_ack_strobe_n;
        logic rd_n;
        logic wr_n;
    } periph_strobes_t;

    typedef enum logic [3:0] {
        IO_IDLE  = 4'b0001,
        IO_SETUP = 4'b0010,
        IO_WAIT  = 4'b0100,
        IO_HOLD  = 4'b1000
    } io_state_t;

endpackage

// *** cpu_periph_glue.sv ***
// CPU-to-peripheral glue: delayed I/O strobes, wait generator, interrupt acknowledge
//
// Functional notes
// RULE1: Peripheral read strobe falls on a system clock rising edge, after address setup.
// RULE2: Peripheral write strobe falls on a system clock rising edge, after setup.
// RULE3: I/O read holds CPU in wait until peripheral read data is valid.
// RULE4: Slower grade with delayed write: two extra wait states per I/O write.
// RULE5: Faster grade with delayed read: one extra wait state per I/O read.
// RULE6: Faster grade with delayed write: one extra wait state per I/O write.
// RULE7: Same wait count may be used for reads and writes.
// RULE8: Waits apply to every I/O cycle or only peripheral-family cycles.
// RULE9: Acknowledge strobe is synchronised to the peripheral clock when clocks differ.
// RULE10: Glue creates both acknowledge strobe and read strobe during acknowledge.
// RULE11: Wait stays active until the interrupt vector is valid.
// RULE12: Delay between acknowledge and read lets the daisy chain settle.
// RULE13: No return-from-interrupt opcode decoding is performed.
// RULE14: Peripherals clear in-service flag only on a software reset command.
// RULE15: One shift register yields acknowledge, read strobe and wait from chosen stages.
// RULE16: Acknowledge detected at T2 rising edge: opcode fetch active, memory request idle.
// RULE17: Outside acknowledge, shift register cleared; peripheral strobes follow CPU strobes.
// RULE18: During system reset, peripheral read and write strobes are driven together.
// RULE19: Each chip enable is decoded address gated by the I/O request strobe.
// RULE20: Wait counts and read/wait tap are build-time parameters.
// RULE21: Opcode fetch release ends acknowledge: strobes, wait and shift register cleared.
`timescale 1ns/1ps

module cpu_periph_glue
    import glue_pkg::*;
#(
    parameter int RD_WAITS   = RD_WAITS_DEF,   // [RULE20]
    parameter int WR_WAITS   = WR_WAITS_DEF,   // [RULE20]
    parameter int ACK_SR_LEN = ACK_SR_LEN_DEF,
    parameter int ACK_RD_TAP = ACK_RD_TAP_DEF, // [RULE20]
    parameter int NUM_CE     = 4
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              opcode_fetch_strobe_n,
    input  wire logic              memory_request_strobe_n,
    input  wire logic              io_request_strobe_n,
    input  wire logic              cpu_rd_n,
    input  wire logic              cpu_wr_n,
    input  wire logic [NUM_CE-1:0] addr_decode,
    input  wire logic              waits_family_only,
    input  wire logic              system_wait_n,
    output logic                   periph_rd_n,
    output logic                   periph_wr_n,
    output logic                   irq_ack_strobe_n,
    output logic [NUM_CE-1:0]      periph_ce_n,
    output logic                   cpu_wait_n
);

    // Elaboration checks: a count wider than the counter would silently wrap
    if (RD_WAITS < 0 || RD_WAITS >= (1 << WAIT_CNT_W) ||
        WR_WAITS < 0 || WR_WAITS >= (1 << WAIT_CNT_W)) begin : g_bad_waits
        $error("wait-state count out of range");
    end
    if (ACK_RD_TAP < 1 || ACK_RD_TAP >= ACK_SR_LEN) begin : g_bad_tap
        $error("acknowledge tap must lie inside the shift register");
    end
    if (NUM_CE < 1) begin : g_bad_ce
        $error("need at least one chip enable");
    end

    // Two-flop synchronisers for the CPU pins; the peripheral clock is this clock
    cpu_strobes_t       pins_in;
    cpu_strobes_t       meta_reg;
    cpu_strobes_t       sync_reg;
    logic [NUM_CE-1:0]  dec_meta_reg;
    logic [NUM_CE-1:0]  dec_sync_reg;
    logic               fam_meta_reg;
    logic               fam_sync_reg;
    logic               wait_meta_reg;
    logic               wait_sync_reg;

    assign pins_in = '{opcode_fetch_n:   opcode_fetch_strobe_n,
                       memory_request_n: memory_request_strobe_n,
                       io_request_n:     io_request_strobe_n,
                       rd_n:             cpu_rd_n,
                       wr_n:             cpu_wr_n};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= pins_in;
            sync_reg <= meta_reg;
        end
    end

    // Decode idles at zero so no chip enable pulses straight out of reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_meta_reg <= '0;
            dec_sync_reg <= '0;
        end else begin
            dec_meta_reg <= addr_decode;
            dec_sync_reg <= dec_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fam_meta_reg <= 1'b0;
            fam_sync_reg <= 1'b0;
        end else begin
            fam_meta_reg <= waits_family_only;
            fam_sync_reg <= fam_meta_reg;
        end
    end

    // Outside wait idles released, so reset never stalls the CPU
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_meta_reg <= 1'b1;
            wait_sync_reg <= 1'b1;
        end else begin
            wait_meta_reg <= system_wait_n;
            wait_sync_reg <= wait_meta_reg;
        end
    end

    // Interrupt acknowledge: detection and shift register
    // Early detect at T2 avoids waiting for the late I/O request of the acknowledge.
    logic                  m1_act;
    logic                  ack_detect;
    logic                  synced_ack_detect_reg;
    logic [ACK_SR_LEN-1:0] ack_sr_reg;
    logic [ACK_SR_LEN-1:0] ack_sr_next;
    logic                  ack_rd_tap;

    assign m1_act     = ~sync_reg.opcode_fetch_n;
    assign ack_detect = m1_act & sync_reg.memory_request_n;                 // [RULE16] [RULE13]
    // Registering the detect on this clock is the sync to the peripheral clock
    // Stage 0 feeds back so the chain stays filled until opcode fetch releases
    assign ack_sr_next = m1_act ? {ack_sr_reg[ACK_SR_LEN-2:0],
                                   synced_ack_detect_reg | ack_sr_reg[0]}
                                : '0;                                        // [RULE17] [RULE21]
    assign ack_rd_tap  = ack_sr_reg[ACK_RD_TAP];                             // [RULE12]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            synced_ack_detect_reg <= 1'b0;
        end else begin
            synced_ack_detect_reg <= ack_detect & ~ack_sr_reg[0];            // [RULE9]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_sr_reg <= '0;
        end else begin
            ack_sr_reg <= ack_sr_next;                                       // [RULE15]
        end
    end

    // Sticky: once set, the chain of ones stays filled while opcode fetch holds
    logic ack_active;
    assign ack_active = ack_sr_reg[0];

    // I/O cycle wait generator
    logic                  io_cycle;
    logic                  io_rd;
    logic                  io_wr;
    logic                  family_hit;
    logic                  waits_apply;
    logic [WAIT_CNT_W-1:0] wait_load;
    io_state_t             io_state_reg;
    io_state_t             io_state_next;
    logic [WAIT_CNT_W-1:0] wait_cnt_reg;
    logic [WAIT_CNT_W-1:0] wait_cnt_next;
    logic                  strobe_en_reg;
    logic                  strobe_en_next;

    assign io_cycle    = ~sync_reg.io_request_n & ~m1_act;
    assign io_rd       = io_cycle & ~sync_reg.rd_n;
    assign io_wr       = io_cycle & ~sync_reg.wr_n;
    assign family_hit  = |dec_sync_reg;
    assign waits_apply = ~fam_sync_reg | family_hit;                         // [RULE8]
    // Separate read/write counts; equal defaults keep a single-count build simple
    assign wait_load   = io_wr ? WAIT_CNT_W'(WR_WAITS)                       // [RULE4] [RULE6]
                               : WAIT_CNT_W'(RD_WAITS);                      // [RULE5] [RULE7]

    always_comb begin
        io_state_next  = io_state_reg;
        wait_cnt_next  = wait_cnt_reg;
        strobe_en_next = strobe_en_reg;
        case (io_state_reg)
            IO_IDLE: begin
                strobe_en_next = 1'b0;
                if (io_rd | io_wr) begin
                    io_state_next = IO_SETUP;
                    wait_cnt_next = waits_apply ? wait_load : WAIT_CNT_ZERO;
                end
            end
            IO_SETUP: begin
                // Strobe is released on a clock rising edge, one clock after detection
                strobe_en_next = 1'b1;                                       // [RULE1] [RULE2]
                io_state_next  = (wait_cnt_reg == WAIT_CNT_ZERO) ? IO_HOLD : IO_WAIT;
            end
            IO_WAIT: begin
                wait_cnt_next = wait_cnt_reg - 1'b1;                         // [RULE3]
                if (wait_cnt_reg == 4'h1)
                    io_state_next = IO_HOLD;
            end
            IO_HOLD: begin
                if (~(io_rd | io_wr)) begin
                    io_state_next  = IO_IDLE;
                    strobe_en_next = 1'b0;
                end
            end
            default: begin
                io_state_next  = IO_IDLE;
                wait_cnt_next  = WAIT_CNT_ZERO;
                strobe_en_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_state_reg <= IO_IDLE;
        end else begin
            io_state_reg <= io_state_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt_reg <= WAIT_CNT_ZERO;
        end else begin
            wait_cnt_reg <= wait_cnt_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_en_reg <= 1'b0;
        end else begin
            strobe_en_reg <= strobe_en_next;
        end
    end

    // Wait is driven before the CPU samples it: the state is known from detection
    logic io_wait;
    assign io_wait = ((io_state_reg == IO_IDLE) & (io_rd | io_wr) & waits_apply &
                      (wait_load != WAIT_CNT_ZERO)) |
                     (io_state_reg == IO_SETUP & wait_cnt_reg != WAIT_CNT_ZERO) |
                     (io_state_reg == IO_WAIT);                              // [RULE3]

    // Output stage: every output straight from a flop
    logic              rd_next;
    logic              wr_next;
    logic              ack_next;
    logic              wait_next;
    logic [NUM_CE-1:0] ce_next;
    logic              io_req_act;

    assign rd_next   = ~((io_rd & strobe_en_next) | ack_rd_tap);             // [RULE10]
    assign wr_next   = ~(io_wr & strobe_en_next);                            // [RULE17]
    assign ack_next  = ~ack_active;                                          // [RULE10]
    // Wait held from acknowledge until the read tap is reached, i.e. vector valid
    assign wait_next = ~(io_wait | (ack_active & ~ack_rd_tap) |
                         (synced_ack_detect_reg & ~ack_active)) &
                       wait_sync_reg;                                        // [RULE11]
    assign io_req_act = ~sync_reg.io_request_n;

    // One enable per peripheral; each is its decode gated by the I/O request
    for (genvar ch = 0; ch < NUM_CE; ch++) begin : g_ce
        assign ce_next[ch] = ~(dec_sync_reg[ch] & io_req_act);              // [RULE19]
    end

    // Both strobes low together is the peripheral reset indication
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_rd_n <= 1'b0;                                             // [RULE18]
        end else begin
            periph_rd_n <= rd_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_wr_n <= 1'b0;                                             // [RULE18]
        end else begin
            periph_wr_n <= wr_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack_strobe_n <= 1'b1;
        end else begin
            irq_ack_strobe_n <= ack_next;                                    // [RULE15]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_ce_n <= '1;
        end else begin
            periph_ce_n <= ce_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_wait_n <= 1'b1;
        end else begin
            cpu_wait_n <= wait_next;                                         // [RULE15]
        end
    end

endmodule // cpu_periph_glue

// *** glue_assertions.sv ***
// Port-level checker for the CPU-to-peripheral glue
`timescale 1ns/1ps

module glue_assertions #(
    parameter int WAITS      = 1,
    parameter int ACK_RD_TAP = 3,
    parameter int NUM_CE     = 4
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              opcode_fetch_strobe_n,
    input wire logic              io_request_strobe_n,
    input wire logic              cpu_rd_n,
    input wire logic              cpu_wr_n,
    input wire logic [NUM_CE-1:0] addr_decode,
    input wire logic              system_wait_n,
    input wire logic              periph_rd_n,
    input wire logic              periph_wr_n,
    input wire logic              irq_ack_strobe_n,
    input wire logic [NUM_CE-1:0] periph_ce_n,
    input wire logic              cpu_wait_n
);
    logic [3:0] wait_len;
    logic       sys_seen;
    logic       rst_held;

    // Reset is checked from its second edge on, once the outputs have settled
    always_ff @(posedge clk) begin
        rst_held <= !rst_n;
    end

    // Outside waits from other system logic would lengthen the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_len <= 4'h0;
            sys_seen <= 1'b0;
        end else begin
            wait_len <= cpu_wait_n ? 4'h0 : wait_len + 4'h1;
            sys_seen <= !system_wait_n || (sys_seen && !cpu_wait_n);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_reset_strobes;
        disable iff (1'b0) rst_held && !rst_n
            |-> !periph_rd_n && !periph_wr_n && irq_ack_strobe_n;
    endproperty
    a_reset_strobes: assert property (p_reset_strobes) else $error("reset strobes wrong");
    property p_io_rd_delayed;
        $fell(periph_rd_n) && irq_ack_strobe_n && (periph_ce_n != '1)
            |-> $past(!cpu_rd_n, 2) && !cpu_wait_n;
    endproperty
    a_io_rd_delayed: assert property (p_io_rd_delayed) else $error("read strobe early");
    property p_io_wr_delayed;
        $fell(periph_wr_n) && (periph_ce_n != '1) |-> $past(!cpu_wr_n, 2) && !cpu_wait_n;
    endproperty
    a_io_wr_delayed: assert property (p_io_wr_delayed) else $error("write strobe early");
    property p_io_wait_len;
        $rose(cpu_wait_n) && irq_ack_strobe_n && !sys_seen |-> wait_len == WAITS + 2;
    endproperty
    a_io_wait_len: assert property (p_io_wait_len) else $error("I/O wait length wrong");
    property p_ce_gate;
        $fell(io_request_strobe_n) && addr_decode[0] |-> ##[2:4] !periph_ce_n[0];
    endproperty
    a_ce_gate: assert property (p_ce_gate) else $error("chip enable missing");
    property p_ack_wait_held;
        !irq_ack_strobe_n && periph_rd_n |-> !cpu_wait_n;
    endproperty
    a_ack_wait_held: assert property (p_ack_wait_held) else $error("wait dropped early");
    property p_ack_rd_tap;
        $fell(periph_rd_n) && !irq_ack_strobe_n |-> $past(irq_ack_strobe_n, ACK_RD_TAP + 1)
            && !$past(irq_ack_strobe_n, ACK_RD_TAP) && $rose(cpu_wait_n);
    endproperty
    a_ack_rd_tap: assert property (p_ack_rd_tap) else $error("ack to read delay wrong");
    property p_ack_end;
        $rose(irq_ack_strobe_n) |-> periph_rd_n && cpu_wait_n && $past(opcode_fetch_strobe_n, 2);
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("ack end wrong");
endmodule // glue_assertions

// *** periph_model.sv ***
// Peripheral on the far side: in-service flag and daisy-chain settle count
`timescale 1ns/1ps

module periph_model (
    input  wire logic  clk,
    input  wire logic  ce_n,
    input  wire logic  rd_n,
    input  wire logic  wr_n,
    input  wire logic  ack_n,
    output logic       in_service_flag,
    output logic [3:0] settle_cnt
);
    always @(posedge clk) begin
        if (!rd_n && !wr_n)
            in_service_flag <= 1'b0; // Both strobes low is a device reset
        else if (!ack_n && !rd_n)
            in_service_flag <= 1'b1; // Vector read marks the device under service
        else if (!ce_n && !wr_n)
            in_service_flag <= 1'b0; // Besides a device reset, only a written command clears it
        settle_cnt <= ack_n ? 4'h0 : (rd_n ? settle_cnt + 4'h1 : settle_cnt);
    end
endmodule // periph_model

// *** tb_top.sv ***
// Self-checking bench for the CPU-to-peripheral glue
`timescale 1ns/1ps

module tb_top;
    import glue_pkg::*;
    localparam int WAITS = 1;
    localparam int TAP   = 3;
    typedef struct {
        logic       wr;
        logic       fam;
        logic [3:0] addr;
        int         wlen;
    } row_t;
    row_t rows[5] = '{'{0, 0, 4'h1, WAITS + 2}, '{1, 0, 4'h0, WAITS + 2},
        '{0, 1, 4'h0, 0}, '{1, 1, 4'h8, WAITS + 2}, '{0, 1, 4'h4, WAITS + 2}};
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    cpu_strobes_t cpu = 5'h1F;
    logic [3:0]   addr = 4'h0;
    logic         fam = 1'b0;
    logic         sys_wait_n = 1'b1;
    logic         periph_rd_n, periph_wr_n, irq_ack_strobe_n, cpu_wait_n, in_svc;
    logic [3:0]   periph_ce_n, settle, ce;
    logic         sl;
    int           n_fail = 0, check_count = 0, wl, ta, tr;

    cpu_periph_glue #(.RD_WAITS(WAITS), .WR_WAITS(WAITS), .ACK_RD_TAP(TAP)) u_dut (
        .clk, .rst_n, .opcode_fetch_strobe_n(cpu.opcode_fetch_n),
        .memory_request_strobe_n(cpu.memory_request_n), .io_request_strobe_n(cpu.io_request_n),
        .cpu_rd_n(cpu.rd_n), .cpu_wr_n(cpu.wr_n), .addr_decode(addr), .waits_family_only(fam),
        .system_wait_n(sys_wait_n), .periph_rd_n, .periph_wr_n, .irq_ack_strobe_n,
        .periph_ce_n, .cpu_wait_n);
    periph_model u_periph (.clk, .ce_n(periph_ce_n[0]), .rd_n(periph_rd_n), .wr_n(periph_wr_n),
        .ack_n(irq_ack_strobe_n), .in_service_flag(in_svc), .settle_cnt(settle));

    initial forever #20 clk = ~clk;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic do_reset(input int n);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
        chk("reset_strobes", 3'b001, {periph_rd_n, periph_wr_n, irq_ack_strobe_n});
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // The CPU holds each cycle for 11 clocks, longer than the WAITS + 2 clocks of wait the glue asks for here
    task automatic io_cycle(input row_t r);
        wl = 0;
        sl = 1'b0;
        ce = 4'hF;
        @(posedge clk);
        cpu <= {2'b11, 1'b0, r.wr, !r.wr};
        addr <= r.addr;
        fam <= r.fam;
        repeat (10) begin
            @(posedge clk);
            #1;
            if (cpu_wait_n === 1'b0) wl++;
            if ((r.wr ? periph_wr_n : periph_rd_n) === 1'b0) sl = 1'b1;
            ce &= periph_ce_n;
        end
        @(posedge clk);
        cpu <= 5'h1F;
        repeat (5) @(posedge clk);
    endtask

    initial begin
        do_reset(16);
        foreach (rows[i]) begin
            io_cycle(rows[i]);
            chk("wait_cycles", rows[i].wlen, wl);
            chk("strobe_low", 1, sl);
            chk("chip_enable", {~rows[i].addr}, ce);
        end
        ta = -1;
        tr = -1;
        @(posedge clk);
        cpu <= 5'h0F;
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            #1;
            if (ta < 0 && irq_ack_strobe_n === 1'b0) ta = k;
            if (tr < 0 && periph_rd_n === 1'b0) tr = k;
        end
        chk("ack_seen", 1, ta >= 0);
        chk("ack_to_read", TAP, tr - ta);
        chk("wait_released", 1, cpu_wait_n);
        chk("settle", TAP, settle);
        chk("in_service_set", 1, in_svc);
        @(posedge clk);
        cpu <= 5'h1F;
        repeat (5) @(posedge clk);
        #1;
        chk("ack_end", 3'b111, {irq_ack_strobe_n, periph_rd_n, cpu_wait_n});
        ta = -1;
        @(posedge clk);
        cpu <= 5'h05;
        repeat (10) begin
            @(posedge clk);
            #1;
            if (irq_ack_strobe_n !== 1'b1) ta = 0;
        end
        chk("fetch_no_ack", -1, ta);
        @(posedge clk);
        cpu <= 5'h1F;
        repeat (5) @(posedge clk);
        #1;
        chk("in_service_kept", 1, in_svc);
        io_cycle('{1, 0, 4'h1, WAITS + 2});
        chk("in_service_clr", 0, in_svc);
        @(posedge clk);
        sys_wait_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("system_wait", 0, cpu_wait_n);
        @(posedge clk);
        sys_wait_n <= 1'b1;
        repeat (6) @(posedge clk);
        do_reset(3);
        chk("after_reset", 2'b11, {periph_rd_n, periph_wr_n});
        stop_test();
    end
endmodule // tb_top

bind cpu_periph_glue glue_assertions #(.WAITS(RD_WAITS), .ACK_RD_TAP(ACK_RD_TAP),
    .NUM_CE(NUM_CE)) u_chk (.clk, .rst_n, .opcode_fetch_strobe_n, .io_request_strobe_n,
    .cpu_rd_n, .cpu_wr_n, .addr_decode, .system_wait_n, .periph_rd_n, .periph_wr_n,
    .irq_ack_strobe_n, .periph_ce_n, .cpu_wait_n);
